//--- design/uvp_programmer.sv
`timescale 1ns/10ps
`include "uvp_defines.svh"
module uvp_programmer #(
    parameter int NDEV       = 4,
    parameter int PULSE_CYC  = `UVP_PULSE_CYC,
    parameter int PULSE_MAX  = `UVP_PULSE_MAX_CYC,
    parameter int VDD_CYC    = `UVP_VDD_CYC,
    parameter int SETUP_CYC  = `UVP_SETUP_CYC
) (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire uvp_pkg::uvp_req_type reqData,
    input  wire logic                 reqValid,
    output logic                      reqReady,
    output uvp_pkg::uvp_resp_type     respData,
    output logic                      respValid,
    output logic [11:0]               romAddr,
    output logic [NDEV-1:0]           romChipSelN,
    output logic                      romVppEn,
    output logic                      romGateN,
    output logic [7:0]                romDataOut,
    output logic                      romDataOe,
    input  wire logic [7:0]           romDataIn
);

    localparam int CW = 22;
    localparam logic [CW-1:0] PULSE_END = CW'(PULSE_CYC < PULSE_MAX ? PULSE_CYC : PULSE_MAX);
    localparam logic [CW-1:0] VDD_END   = CW'(VDD_CYC);
    localparam logic [CW-1:0] SETUP_END = CW'(SETUP_CYC);

    uvp_pkg::uvp_state_type state_reg;
    uvp_pkg::uvp_state_type state_next;
    uvp_pkg::uvp_req_type   req_reg;
    uvp_pkg::uvp_req_type   req_next;
    uvp_pkg::uvp_resp_type  resp_reg;
    uvp_pkg::uvp_resp_type  resp_next;
    logic [CW-1:0]          count_reg;
    logic [CW-1:0]          count_next;
    logic                   respValid_reg;
    logic                   respValid_next;
    logic [NDEV-1:0]        cs_reg;
    logic [NDEV-1:0]        cs_next;
    logic                   vpp_reg;
    logic                   vpp_next;
    logic                   gate_reg;
    logic                   gate_next;
    logic                   oe_reg;
    logic                   oe_next;
    logic [7:0]             pinData;

    uvp_sync #(.WIDTH(8)) u_sync (
        .clk     (clk),
        .rst     (rst),
        .asyncIn (romDataIn),
        .syncOut (pinData)
    );

    // Strobe pattern: selected devices low, the rest held high
    function automatic logic [NDEV-1:0] strobeFor(input logic [3:0] mask);
        logic [NDEV-1:0] s;
        s = '1;
        for (int i = 0; i < NDEV; i++) begin
            if (mask[i]) begin
                s[i] = 1'b0;
            end
        end
        return s;
    endfunction : strobeFor

    always_comb begin
        state_next     = state_reg;
        req_next       = req_reg;
        resp_next      = resp_reg;
        count_next     = count_reg + CW'(1);
        respValid_next = 1'b0;
        cs_next        = cs_reg;
        vpp_next       = vpp_reg;
        gate_next      = gate_reg;
        oe_next        = oe_reg;
        case (state_reg)
            uvp_pkg::ST_IDLE: begin
                count_next = '0;
                cs_next    = '1;
                if (reqValid) begin
                    req_next   = reqData;
                    state_next = uvp_pkg::ST_SETUP;
                    if (reqData.cmd == `UVP_CMD_PROGRAM) begin
                        vpp_next  = 1'b1;
                        gate_next = 1'b1;
                        oe_next   = 1'b1;
                    end else begin
                        vpp_next  = 1'b0;
                        gate_next = 1'b0;
                        oe_next   = 1'b0;
                    end
                end
            end
            uvp_pkg::ST_SETUP: begin
                // Address, data and supply settle before the strobe falls
                if (count_reg >= SETUP_END) begin
                    count_next = '0;
                    cs_next    = strobeFor(req_reg.selMask);
                    if (req_reg.cmd == `UVP_CMD_PROGRAM) begin
                        state_next = uvp_pkg::ST_PULSE;
                    end else begin
                        state_next = uvp_pkg::ST_VERIFY;
                    end
                end
            end
            uvp_pkg::ST_PULSE: begin
                // One bounded pulse per request, capped at the longest width
                if (count_reg >= PULSE_END - CW'(1)) begin
                    cs_next    = '1;
                    count_next = '0;
                    state_next = uvp_pkg::ST_HOLD;
                end
            end
            uvp_pkg::ST_HOLD: begin
                // Data and supply held after the strobe rises
                if (count_reg >= SETUP_END) begin
                    oe_next    = 1'b0;
                    vpp_next   = 1'b0;
                    gate_next  = 1'b0;
                    state_next = uvp_pkg::ST_DONE;
                end
            end
            uvp_pkg::ST_VERIFY: begin
                // Sample after the verify delay plus the synchroniser lag
                if (count_reg >= VDD_END + CW'(2)) begin
                    resp_next.readData  = pinData;
                    resp_next.match     = (pinData == req_reg.data);
                    resp_next.zeroToOne = |(req_reg.data & ~pinData);
                    respValid_next      = 1'b1;
                    cs_next             = '1;
                    state_next          = uvp_pkg::ST_IDLE;
                end
            end
            uvp_pkg::ST_DONE: begin
                resp_next      = '{readData: req_reg.data, match: 1'b1, zeroToOne: 1'b0};
                respValid_next = 1'b1;
                state_next     = uvp_pkg::ST_IDLE;
            end
            default: begin
                state_next = uvp_pkg::ST_IDLE;
                cs_next    = '1;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg     <= uvp_pkg::ST_IDLE;
            req_reg       <= '0;
            resp_reg      <= '{readData: `UVP_ERASED_BYTE, match: 1'b0, zeroToOne: 1'b0};
            count_reg     <= '0;
            respValid_reg <= 1'b0;
            cs_reg        <= '1;
            vpp_reg       <= 1'b0;
            gate_reg      <= 1'b0;
            oe_reg        <= 1'b0;
        end else begin
            state_reg     <= state_next;
            req_reg       <= req_next;
            resp_reg      <= resp_next;
            count_reg     <= count_next;
            respValid_reg <= respValid_next;
            cs_reg        <= cs_next;
            vpp_reg       <= vpp_next;
            gate_reg      <= gate_next;
            oe_reg        <= oe_next;
        end
    end

    assign reqReady    = (state_reg == uvp_pkg::ST_IDLE);
    assign respData    = resp_reg;
    assign respValid   = respValid_reg;
    assign romAddr     = req_reg.addr;
    assign romChipSelN = cs_reg;
    assign romVppEn    = vpp_reg;
    assign romGateN    = gate_reg;
    assign romDataOut  = req_reg.data;
    assign romDataOe   = oe_reg;

endmodule : uvp_programmer

//--- design/uvp_sync.sv
`timescale 1ns/10ps
// Two-flop synchroniser for pin inputs
module uvp_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage1_next;
    logic [WIDTH-1:0] stage2_reg;
    logic [WIDTH-1:0] stage2_next;

    always_comb begin
        stage1_next = asyncIn;
        stage2_next = stage1_reg;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
        end else begin
            stage1_reg <= stage1_next;
            stage2_reg <= stage2_next;
        end
    end

    assign syncOut = stage2_reg;

endmodule : uvp_sync

//--- inc/uvp_defines.svh
`ifndef UVP_DEFINES_SVH
`define UVP_DEFINES_SVH

// Clock period in picoseconds (40 MHz)
`define UVP_CLK_PS            25000
// Program pulse nominal width, 50 ms, in microseconds
`define UVP_PULSE_US          50000
// Program pulse longest width, 55 ms, in microseconds
`define UVP_PULSE_MAX_US      55000
// Verify data delay, 1 us, in nanoseconds
`define UVP_VDD_NS            1000
// Setup and hold around the pulse, 2 us, in nanoseconds
`define UVP_SETUP_NS          2000
// Cycle counts derived from the times (minimums round up, maximums round down)
`define UVP_PULSE_CYC         ((`UVP_PULSE_US * 1000 + `UVP_CLK_PS / 1000 - 1) / (`UVP_CLK_PS / 1000))
`define UVP_PULSE_MAX_CYC     ((`UVP_PULSE_MAX_US * 1000) / (`UVP_CLK_PS / 1000))
`define UVP_VDD_CYC           ((`UVP_VDD_NS * 1000 + `UVP_CLK_PS - 1) / `UVP_CLK_PS)
`define UVP_SETUP_CYC         ((`UVP_SETUP_NS * 1000 + `UVP_CLK_PS - 1) / `UVP_CLK_PS)
// Command codes
`define UVP_CMD_PROGRAM       1'b0
`define UVP_CMD_VERIFY        1'b1
// Erased byte value
`define UVP_ERASED_BYTE       8'hFF

`endif

//--- inc/uvp_pkg.sv
package uvp_pkg;

    typedef struct packed {
        logic        cmd;
        logic [11:0] addr;
        logic [7:0]  data;
        logic [3:0]  selMask;
    } uvp_req_type;

    typedef struct packed {
        logic [7:0] readData;
        logic       match;
        logic       zeroToOne;
    } uvp_resp_type;

    typedef enum logic [5:0] {
        ST_IDLE   = 6'h01,
        ST_SETUP  = 6'h02,
        ST_PULSE  = 6'h04,
        ST_HOLD   = 6'h08,
        ST_VERIFY = 6'h10,
        ST_DONE   = 6'h20
    } uvp_state_type;

endpackage : uvp_pkg

//--- tb/uv_prom_program_verify_test.sv
`timescale 1ns/10ps
module uv_prom_program_verify_test;
    logic                  clk = 1'b0;
    logic                  rst = 1'b1;
    uvp_pkg::uvp_req_type  reqData = '0;
    logic                  reqValid = 1'b0;
    logic                  reqReady, respValid, romVppEn, romGateN, romDataOe;
    uvp_pkg::uvp_resp_type respData, r;
    logic [11:0]           romAddr;
    logic [3:0]            romChipSelN;
    logic [7:0]            romDataOut, romDataIn;
    int                    err_total = 0;
    int                    num_checks = 0;
    int                    w;
    always #12.5 clk = ~clk;
    uvp_programmer #(.PULSE_CYC(20), .PULSE_MAX(22), .SETUP_CYC(3), .VDD_CYC(4))
        i_uvp_programmer (.clk(clk), .rst(rst), .reqData(reqData), .reqValid(reqValid),
        .reqReady(reqReady), .respData(respData), .respValid(respValid), .romAddr(romAddr),
        .romChipSelN(romChipSelN), .romVppEn(romVppEn), .romGateN(romGateN),
        .romDataOut(romDataOut), .romDataOe(romDataOe), .romDataIn(romDataIn));
    uvp_rom_model #(.DLY(2)) i_uvp_rom_model (.clk(clk), .romAddr(romAddr),
        .romChipSelN(romChipSelN), .romVppEn(romVppEn), .romGateN(romGateN),
        .romDataOut(romDataOut), .romDataIn(romDataIn));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task automatic report_and_stop();
        $display("Checks %0d, errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic run_req(input logic cmd, input logic [11:0] a, input logic [7:0] d,
        input logic [3:0] s);
        int   n;
        logic seen;
        n = 0;
        w = 0;
        seen = 1'b0;
        reqValid <= 1'b1;
        reqData <= '{cmd, a, d, s};
        // Ready read half a cycle before the edge that takes the request
        while (!seen && n < 1000) begin
            @(negedge clk);
            seen = (reqReady === 1'b1);
            @(posedge clk);
            n++;
        end
        reqValid <= 1'b0;
        seen = 1'b0;
        // Outputs read mid-cycle, where they are settled
        while (!seen && n < 1000) begin
            @(negedge clk);
            seen = (respValid === 1'b1);
            w += (romChipSelN != 4'hF);
            n++;
        end
        if (!seen) begin
            err_total++;
            report_and_stop();
        end
        r = respData;
        @(posedge clk);
    endtask : run_req
    task automatic pgm(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s);
        run_req(1'b0, a, d, s);
        check(w, 20);
        check(r.match, 1'b1);
    endtask : pgm
    task automatic vfy(input logic [11:0] a, input logic [7:0] want, input logic [3:0] s,
        input logic [7:0] exp);
        run_req(1'b1, a, want, s);
        check(r.readData, exp);
        check({r.match, r.zeroToOne}, {exp == want, |(want & ~exp)});
    endtask : vfy
    task automatic scen_program();
        vfy(12'h005, 8'hFF, 4'h1, 8'hFF);
        pgm(12'h123, 8'hA5, 4'h1);
        vfy(12'h123, 8'hA5, 4'h1, 8'hA5);
        pgm(12'h123, 8'hFF, 4'h1);
        vfy(12'h123, 8'hFF, 4'h1, 8'hA5);
    endtask : scen_program
    task automatic scen_any_order();
        pgm(12'hFFF, 8'h5A, 4'h2);
        pgm(12'h000, 8'hC3, 4'h2);
        vfy(12'h000, 8'hC3, 4'h2, 8'hC3);
        vfy(12'hFFF, 8'h5A, 4'h2, 8'h5A);
    endtask : scen_any_order
    task automatic scen_shared();
        pgm(12'h040, 8'h3C, 4'h4);
        vfy(12'h040, 8'h3C, 4'h8, 8'hFF);
        vfy(12'h040, 8'h3C, 4'h4, 8'h3C);
        pgm(12'h050, 8'h0F, 4'hC);
        vfy(12'h050, 8'h0F, 4'h4, 8'h0F);
        vfy(12'h050, 8'h0F, 4'h8, 8'h0F);
    endtask : scen_shared
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check({romChipSelN, romVppEn, romDataOe}, 6'h3C);
        check(respData.readData, 8'hFF);
        @(posedge clk);
        scen_program();
        scen_any_order();
        scen_shared();
        report_and_stop();
    end
endmodule : uv_prom_program_verify_test

//--- tb/uvp_checker.sv
`timescale 1ns/10ps
module uvp_checker #(
    parameter int NDEV      = 4,
    parameter int PULSE_CYC = 20,
    parameter int PULSE_MAX = 22,
    parameter int VDD_CYC   = 4
) (
    input wire logic                 clk,
    input wire logic                 rst,
    input wire uvp_pkg::uvp_req_type reqData,
    input wire logic                 reqValid,
    input wire logic                 reqReady,
    input wire logic                 respValid,
    input wire logic [11:0]          romAddr,
    input wire logic [NDEV-1:0]      romChipSelN,
    input wire logic                 romVppEn,
    input wire logic                 romGateN,
    input wire logic [7:0]           romDataOut,
    input wire logic                 romDataOe
);
    localparam int PLEN  = (PULSE_CYC < PULSE_MAX) ? PULSE_CYC : PULSE_MAX;
    localparam int VWAIT = VDD_CYC + 3;
    logic [31:0]     lowReg;
    logic [31:0]     lowNext;
    logic [NDEV-1:0] selReg;
    logic [NDEV-1:0] selNext;
    logic            strobeOn;
    assign strobeOn = ~&romChipSelN;
    // Strobe low length and captured device selection
    always_comb begin
        lowNext = strobeOn ? lowReg + 32'h1 : 32'h0;
        selNext = (reqValid && reqReady) ? reqData.selMask[NDEV-1:0] : selReg;
    end
    always_ff @(posedge clk) begin
        lowReg <= rst ? 32'h0 : lowNext;
        selReg <= rst ? '0 : selNext;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    pulse_max_a: assert property (lowReg <= PULSE_MAX)
        else $error("strobe held low too long");
    pulse_width_a: assert property ($fell(strobeOn) && romVppEn |-> lowReg == PLEN)
        else $error("program pulse width wrong");
    hold_stable_a: assert property (strobeOn && romVppEn |-> $stable(romAddr)
        && $stable(romDataOut)) else $error("address or data moved in pulse");
    pgm_mode_a: assert property (strobeOn && romVppEn |-> romGateN && romDataOe)
        else $error("program pulse without supply or data drive");
    verify_mode_a: assert property (strobeOn && !romVppEn |-> !romGateN && !romDataOe)
        else $error("verify strobe with gate high or data driven");
    verify_time_a: assert property ($rose(strobeOn) && !romVppEn |-> ##[VDD_CYC:VWAIT] respValid)
        else $error("verify answer late");
    idle_safe_a: assert property (reqReady |-> !strobeOn && !romVppEn && !romDataOe)
        else $error("idle with strobe, supply or data active");
    strobe_sel_a: assert property (strobeOn |-> ~romChipSelN == selReg)
        else $error("strobe on unselected device");
    pgm_pulse_c: cover property ($fell(strobeOn) && romVppEn);
    verify_c: cover property ($rose(strobeOn) && !romVppEn);
    multi_dev_c: cover property (strobeOn && $countones(romChipSelN) < NDEV - 1);
endmodule : uvp_checker

bind uvp_programmer uvp_checker #(.NDEV(NDEV), .PULSE_CYC(PULSE_CYC), .PULSE_MAX(PULSE_MAX),
    .VDD_CYC(VDD_CYC)) i_uvp_checker (.clk(clk), .rst(rst), .reqData(reqData),
    .reqValid(reqValid), .reqReady(reqReady), .respValid(respValid), .romAddr(romAddr),
    .romChipSelN(romChipSelN), .romVppEn(romVppEn), .romGateN(romGateN),
    .romDataOut(romDataOut), .romDataOe(romDataOe));

//--- tb/uvp_rom_model.sv
`timescale 1ns/10ps
module uvp_rom_model #(
    parameter int NDEV = 4,
    parameter int DLY  = 2
) (
    input wire logic            clk,
    input wire logic [11:0]     romAddr,
    input wire logic [NDEV-1:0] romChipSelN,
    input wire logic            romVppEn,
    input wire logic            romGateN,
    input wire logic [7:0]      romDataOut,
    output logic [7:0]          romDataIn
);
    logic [7:0]      memArr [NDEV][4096];
    logic [NDEV-1:0] csPrev = '1;
    logic [7:0]      lastVal = 8'h00;
    logic [7:0]      rdVal;
    logic            verifyOn;
    int              vCnt = 0;
    assign verifyOn = (~&romChipSelN) && !romGateN && !romVppEn;
    assign romDataIn = (verifyOn && vCnt >= DLY) ? rdVal : ~lastVal;
    always_comb begin
        rdVal = 8'hFF;
        for (int d = 0; d < NDEV; d++) begin
            if (!romChipSelN[d]) rdVal &= memArr[d][romAddr];
        end
    end
    initial begin
        foreach (memArr[d, a]) memArr[d][a] = 8'hFF;
    end
    always @(posedge clk) begin
        for (int d = 0; d < NDEV; d++) begin
            if (!csPrev[d] && romChipSelN[d] && romVppEn && romGateN) begin
                memArr[d][romAddr] &= romDataOut;
            end
        end
        csPrev <= romChipSelN;
        vCnt <= verifyOn ? vCnt + 1 : 0;
        if (verifyOn && vCnt >= DLY) lastVal <= rdVal;
    end
endmodule : uvp_rom_model
